// ---- design/lpd_map.vh ----
`ifndef LPD_MAP_VH
`define LPD_MAP_VH
// Register offsets
`define LPD_OFS_PIN_SHARE   8'h39
`define LPD_OFS_DISP_CTRL   8'h3a
`define LPD_OFS_CLK_DRIVE   8'h3b
`define LPD_OFS_STATUS      8'h3c
// Reset values
`define LPD_RST_PIN_SHARE   8'h1f
`define LPD_RST_DISP_CTRL   8'h80
`define LPD_RST_CLK_DRIVE   8'hf0
// Frame buffer window
`define LPD_FB_BASE         13'h1000
`define LPD_FB_HIGH_BASE    13'h1080
`define LPD_FB_LAST         13'h10af
`define LPD_FB_SEGS         48
// Field positions
`define LPD_BIT_PUMP_OFF    7
`define LPD_BIT_BLANK       6
`define LPD_BIT_INVERT      5
`define LPD_BIT_KEY_WAKE    4
`define LPD_BIT_BIAS        5
`define LPD_BIT_SHARE_EN    4
`define LPD_BIT_BYPASS      3
// Drive level codes on the 3-bit level buses
`define LPD_LVL_GND         3'h0
`define LPD_LVL_ONE         3'h1
`define LPD_LVL_TWO         3'h2
`define LPD_LVL_THREE       3'h3
`define LPD_LVL_FOUR        3'h4
`define LPD_LVL_PEAK        3'h5
// Duty codes
`define LPD_DUTY_12         2'h2
`define LPD_DUTY_8          2'h3
// Frame timing at 40 MHz system clock
`define LPD_CLK_HZ          40000000
`define LPD_FRAME_64_HZ     64
`define LPD_FRAME_85_HZ     85
`define LPD_SLOW_OSC_HZ     32768
`define LPD_WAKE_PULSE_CYC  3'h4
`endif

// ---- design/lpd_panel_ctrl.v ----
// How it works
// - Frame buffer at 1000h..102Fh and 1080h..10AFh, read and written as memory.
// - Sixteen commons and 32 fixed segments; 16 more shared with ports.
// - Pump off bit 7 of display control: one is off.
// - Alternation toggles every frame and steers every drive level except the wake pulse peak.
// - Common: selected peak/ground, unselected level one/four.
// - Segment: selected peak/ground, unselected level two/three.
// - Duty field bits 7:6: 0x 1/16, 10 1/12, 11 1/8.
// - Bias bit 5 set gives quarter bias, clear fifth bias.
// - Share enable clear gives ports; set makes first n+1 pads segments.
// - Blank bit 6 hides display while commons keep scanning.
// - Invert bit 5 reverses all pixels.
// - Key wake bit 4 inserts pulses into shared segments.
// - Contrast mapping for 1/16 and 1/8 duty at 64 and 85 Hz.
// - Contrast mapping for 1/12 duty at 64 and 85 Hz.
// - Drive strength bits 7:4, code 0 is level 16 at 1/16 or 1/8 duty and 64 Hz.
// - Bypass bit 3 drives display without the converter.
// - Frame clock field picks source and 64 or 85 Hz rate.
// - Slow oscillator source keeps scanning during power down.
// - Segment n at 1000h+n for commons 0-7, 1080h+n for 8-15.
// - Wake pulses merge into segment waveform for a port A wake.
`timescale 1ns/1ps
`include "lpd_map.vh"
module lpd_panel_ctrl #(
  parameter CLK_HZ = `LPD_CLK_HZ,
  parameter ROW_64_CYC = CLK_HZ / (`LPD_FRAME_64_HZ * 16),
  parameter ROW_85_CYC = CLK_HZ / (`LPD_FRAME_85_HZ * 16),
  parameter SLOW_DIV = CLK_HZ / `LPD_SLOW_OSC_HZ
) (
  input  wire         MCLK_IN,
  input  wire         RST_N_IN,
  input  wire         CLK_EN_IN,
  input  wire [7:0]   REG_ADDR_IN,
  input  wire [7:0]   REG_WDATA_IN,
  input  wire         REG_WR_IN,
  input  wire         REG_RD_IN,
  output reg  [7:0]   REG_RDATA_OUT,
  input  wire [12:0]  FB_ADDR_IN,
  input  wire [7:0]   FB_WDATA_IN,
  input  wire         FB_WR_IN,
  input  wire         FB_RD_IN,
  output reg  [7:0]   FB_RDATA_OUT,
  input  wire         SLOW_OSC_IN,
  input  wire         POWER_DOWN_IN,
  output reg  [47:0]  COM_LEVEL_OUT,
  output reg  [143:0] SEG_LEVEL_OUT,
  output reg  [15:0]  PAD_IS_SEG_OUT,
  output reg          ALT_OUT,
  output reg          PUMP_ON_OUT,
  output reg          PUMP_BYPASS_OUT,
  output reg          QUARTER_BIAS_OUT,
  output reg  [4:0]   CONTRAST_LEVEL_OUT,
  output reg  [4:0]   DRIVE_LEVEL_OUT
);

  reg         rst_s1_q;
  reg         rst_n_q;
  reg  [1:0]  slow_sync_q;
  reg         slow_prev_q;
  reg  [7:0]  pin_share_q;
  reg  [7:0]  disp_ctrl_q;
  reg  [7:0]  clk_drive_q;
  // Low bank bytes 0..47, high bank bytes 48..95
  reg  [7:0]  fb_mem [0:95];
  reg  [19:0] row_cnt_q;
  reg  [3:0]  com_idx_q;
  reg  [2:0]  wake_cnt_q;
  reg  [4:0]  contrast_q;
  reg  [4:0]  drive_q;
  reg  [4:0]  seg_idx;
  reg  [6:0]  fb_idx;
  reg  [19:0] row_len;
  reg  [4:0]  duty_rows;
  reg         sel;
  reg         pix;
  reg         row_tick;
  integer     i;

  wire        fast_85  = clk_drive_q[0];
  wire        use_slow = (clk_drive_q[2:1] == 2'h0);
  wire        slow_edge = slow_sync_q[1] & ~slow_prev_q;
  wire        fb_hit_lo = (FB_ADDR_IN >= `LPD_FB_BASE) &&
                          (FB_ADDR_IN < `LPD_FB_BASE + `LPD_FB_SEGS);
  wire        fb_hit_hi = (FB_ADDR_IN >= `LPD_FB_HIGH_BASE) &&
                          (FB_ADDR_IN <= `LPD_FB_LAST);

  // Level code: peak/ground when selected, middle levels otherwise
  function [2:0] drive_level;
    input is_com;
    input selected;
    input alt;
    begin
      if (selected)
        drive_level = alt ? `LPD_LVL_PEAK : `LPD_LVL_GND;
      else if (is_com)
        drive_level = alt ? `LPD_LVL_ONE : `LPD_LVL_FOUR;
      else
        drive_level = alt ? `LPD_LVL_TWO : `LPD_LVL_THREE;
    end
  endfunction

  // Code to level: level = top - (code - knee) clipped at top
  function [4:0] code_level;
    input [3:0] code;
    input [4:0] top;
    begin
      if ({1'b0, code} + top <= 5'h10)
        code_level = top;
      else
        code_level = 5'h10 - {1'b0, code};
    end
  endfunction

  // Literal table: the knee sits at a different code in each column
  function [4:0] contrast_map;
    input       d12;
    input       f85;
    input [3:0] code;
    begin
      case ({d12, f85, code})
        // Sixteen or eight rows, 64 Hz
        6'h00: contrast_map = 5'd12;
        6'h01: contrast_map = 5'd12;
        6'h02: contrast_map = 5'd12;
        6'h03: contrast_map = 5'd12;
        6'h04: contrast_map = 5'd12;
        6'h05: contrast_map = 5'd11;
        6'h06: contrast_map = 5'd10;
        6'h07: contrast_map = 5'd9;
        6'h08: contrast_map = 5'd8;
        6'h09: contrast_map = 5'd7;
        6'h0a: contrast_map = 5'd6;
        6'h0b: contrast_map = 5'd5;
        6'h0c: contrast_map = 5'd4;
        6'h0d: contrast_map = 5'd3;
        6'h0e: contrast_map = 5'd2;
        6'h0f: contrast_map = 5'd1;

        // Sixteen or eight rows, 85 Hz
        6'h10: contrast_map = 5'd8;
        6'h11: contrast_map = 5'd8;
        6'h12: contrast_map = 5'd8;
        6'h13: contrast_map = 5'd8;
        6'h14: contrast_map = 5'd8;
        6'h15: contrast_map = 5'd8;
        6'h16: contrast_map = 5'd8;
        6'h17: contrast_map = 5'd8;
        6'h18: contrast_map = 5'd8;
        6'h19: contrast_map = 5'd7;
        6'h1a: contrast_map = 5'd6;
        6'h1b: contrast_map = 5'd5;
        6'h1c: contrast_map = 5'd4;
        6'h1d: contrast_map = 5'd3;
        6'h1e: contrast_map = 5'd2;
        6'h1f: contrast_map = 5'd1;

        // Twelve rows, 64 Hz
        6'h20: contrast_map = 5'd16;
        6'h21: contrast_map = 5'd15;
        6'h22: contrast_map = 5'd14;
        6'h23: contrast_map = 5'd13;
        6'h24: contrast_map = 5'd12;
        6'h25: contrast_map = 5'd11;
        6'h26: contrast_map = 5'd10;
        6'h27: contrast_map = 5'd9;
        6'h28: contrast_map = 5'd8;
        6'h29: contrast_map = 5'd7;
        6'h2a: contrast_map = 5'd6;
        6'h2b: contrast_map = 5'd5;
        6'h2c: contrast_map = 5'd4;
        6'h2d: contrast_map = 5'd3;
        6'h2e: contrast_map = 5'd2;
        6'h2f: contrast_map = 5'd1;

        // Twelve rows, 85 Hz
        6'h30: contrast_map = 5'd10;
        6'h31: contrast_map = 5'd10;
        6'h32: contrast_map = 5'd10;
        6'h33: contrast_map = 5'd10;
        6'h34: contrast_map = 5'd10;
        6'h35: contrast_map = 5'd10;
        6'h36: contrast_map = 5'd10;
        6'h37: contrast_map = 5'd9;
        6'h38: contrast_map = 5'd8;
        6'h39: contrast_map = 5'd7;
        6'h3a: contrast_map = 5'd6;
        6'h3b: contrast_map = 5'd5;
        6'h3c: contrast_map = 5'd4;
        6'h3d: contrast_map = 5'd3;
        6'h3e: contrast_map = 5'd2;
        default: contrast_map = 5'd1;
      endcase
    end
  endfunction

  // Drive strength: a clipped ramp, only the top differs per column
  // Same shape as the contrast ramp, so the clipping helper is reused
  function [4:0] drive_map;
    input       d12;
    input       f85;
    input [3:0] code;
    begin
      case ({d12, f85})
        2'b00:   drive_map = code_level(code, 5'd16);
        2'b01:   drive_map = code_level(code, 5'd12);
        2'b10:   drive_map = code_level(code, 5'd11);
        default: drive_map = code_level(code, 5'd8);
      endcase
    end
  endfunction

  // Release delayed two edges so every flop leaves reset together
  always @(posedge MCLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // Row length in system clocks for the chosen rate
  always @*
  begin
    case (pin_share_q[7:6])
      `LPD_DUTY_12: duty_rows = 5'd12;
      `LPD_DUTY_8:  duty_rows = 5'd8;
      default:      duty_rows = 5'd16;
    endcase
    // Slow source rows counted in oscillator edges
    if (use_slow)
      row_len = fast_85 ? 20'd24 : 20'd32;
    else
      row_len = fast_85 ? ROW_85_CYC[19:0] : ROW_64_CYC[19:0];
    row_tick = (row_cnt_q + 20'd1 >= row_len);
  end

  always @(posedge MCLK_IN or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      slow_sync_q <= 2'h0;
      slow_prev_q <= 1'b0;
      pin_share_q <= `LPD_RST_PIN_SHARE;
      disp_ctrl_q <= `LPD_RST_DISP_CTRL;
      clk_drive_q <= `LPD_RST_CLK_DRIVE;
      row_cnt_q   <= 20'h0;
      com_idx_q   <= 4'h0;
      ALT_OUT     <= 1'b0;
      wake_cnt_q  <= 3'h0;
      contrast_q  <= 5'h0c;
      drive_q     <= 5'h01;
      REG_RDATA_OUT <= 8'h00;
      FB_RDATA_OUT  <= 8'h00;
    end
    else if (CLK_EN_IN)
    begin
      slow_sync_q <= {slow_sync_q[0], SLOW_OSC_IN};
      slow_prev_q <= slow_sync_q[1];
      REG_RDATA_OUT <= 8'h00;
      FB_RDATA_OUT  <= 8'h00;
      if (REG_WR_IN)
      begin
        case (REG_ADDR_IN)
          `LPD_OFS_PIN_SHARE: pin_share_q <= REG_WDATA_IN;
          `LPD_OFS_DISP_CTRL: disp_ctrl_q <= REG_WDATA_IN;
          `LPD_OFS_CLK_DRIVE: clk_drive_q <= REG_WDATA_IN;
          default: ;
        endcase
      end
      if (REG_RD_IN)
      begin
        case (REG_ADDR_IN)
          `LPD_OFS_PIN_SHARE: REG_RDATA_OUT <= pin_share_q;
          `LPD_OFS_DISP_CTRL: REG_RDATA_OUT <= disp_ctrl_q;
          `LPD_OFS_CLK_DRIVE: REG_RDATA_OUT <= clk_drive_q;
          // Status is read-only; writes fall to the default branch
          `LPD_OFS_STATUS:    REG_RDATA_OUT <= {3'h0, ALT_OUT, com_idx_q};
          default:            REG_RDATA_OUT <= 8'h00;
        endcase
      end
      if (FB_RD_IN && (fb_hit_lo || fb_hit_hi))
        FB_RDATA_OUT <= fb_mem[fb_hit_hi ? FB_ADDR_IN[5:0] + 7'd48 : FB_ADDR_IN[5:0]];
      // slow source ticks ignore power down
      if (!POWER_DOWN_IN || use_slow)
      begin
        if (!use_slow || slow_edge)
          row_cnt_q <= row_tick ? 20'h0 : row_cnt_q + 20'd1;
        if ((!use_slow || slow_edge) && row_tick)
        begin
          // Wake pulse restarts at every row start
          wake_cnt_q <= `LPD_WAKE_PULSE_CYC;
          if ({1'b0, com_idx_q} + 5'd1 >= duty_rows)
          begin
            com_idx_q <= 4'h0;
            ALT_OUT <= ~ALT_OUT;
            contrast_q <= contrast_map(pin_share_q[7:6] == `LPD_DUTY_12, fast_85,
                                       disp_ctrl_q[3:0]);
            drive_q <= drive_map(pin_share_q[7:6] == `LPD_DUTY_12, fast_85, clk_drive_q[7:4]);
          end
          else
            com_idx_q <= com_idx_q + 4'd1;
        end
        else if (wake_cnt_q != 3'h0)
          wake_cnt_q <= wake_cnt_q - 3'd1;
      end
    end
  end

  // Memory has no reset: contents are undefined until software fills them
  always @(posedge MCLK_IN)
  begin
    // two half buffers for the two common banks
    if (CLK_EN_IN && FB_WR_IN && (fb_hit_lo || fb_hit_hi))
      fb_mem[fb_hit_hi ? FB_ADDR_IN[5:0] + 7'd48 : FB_ADDR_IN[5:0]] <= FB_WDATA_IN;
  end

  // Scan reads the buffer directly; only the bus port is registered
  always @*
  begin
    seg_idx = 5'h0;
    fb_idx = 7'h0;
    sel = 1'b0;
    pix = 1'b0;
    PUMP_ON_OUT = ~disp_ctrl_q[`LPD_BIT_PUMP_OFF];
    PUMP_BYPASS_OUT = clk_drive_q[`LPD_BIT_BYPASS];
    QUARTER_BIAS_OUT = pin_share_q[`LPD_BIT_BIAS];
    CONTRAST_LEVEL_OUT = contrast_q;
    DRIVE_LEVEL_OUT = drive_q;
    for (i = 0; i < 16; i = i + 1)
      COM_LEVEL_OUT[3*i +: 3] = drive_level(1'b1, com_idx_q == i[3:0], ALT_OUT);
    for (i = 0; i < 48; i = i + 1)
    begin
      fb_idx = com_idx_q[3] ? i[6:0] + 7'd48 : i[6:0];
      pix = fb_mem[fb_idx][3'd7 - com_idx_q[2:0]];
      sel = (pix ^ disp_ctrl_q[`LPD_BIT_INVERT]) & ~disp_ctrl_q[`LPD_BIT_BLANK];
      SEG_LEVEL_OUT[3*i +: 3] = drive_level(1'b0, sel, ALT_OUT);
      if (i >= 32 && disp_ctrl_q[`LPD_BIT_KEY_WAKE] && wake_cnt_q != 3'h0)
        SEG_LEVEL_OUT[3*i +: 3] = `LPD_LVL_PEAK;
    end
    for (i = 0; i < 16; i = i + 1)
    begin
      seg_idx = i[4:0];
      PAD_IS_SEG_OUT[i] = pin_share_q[`LPD_BIT_SHARE_EN] &&
                          (seg_idx <= {1'b0, pin_share_q[3:0]});
    end
  end

endmodule // lpd_panel_ctrl

// ---- sim/lpd_glass_model.sv ----
`timescale 1ns/1ps
module lpd_glass_model (
  input  wire logic [47:0]  com_in,
  input  wire logic [143:0] seg_in,
  output logic              dark_out
);
  int d;
  // pixel shown when common and segment both sit at the select level
  always_comb
  begin
    d = int'(com_in[2:0]) - int'(seg_in[2:0]);
    dark_out = (d == 0) && (com_in[2:0] == 3'h5 || com_in[2:0] == 3'h0);
  end
endmodule // lpd_glass_model

// ---- sim/lpd_ctrl_monitor.sv ----
`timescale 1ns/1ps
module lpd_ctrl_monitor (
  input wire logic         MCLK_IN,
  input wire logic         RST_N_IN,
  input wire logic         CLK_EN_IN,
  input wire logic [7:0]   REG_ADDR_IN,
  input wire logic [7:0]   REG_WDATA_IN,
  input wire logic         REG_WR_IN,
  input wire logic         REG_RD_IN,
  input wire logic [12:0]  FB_ADDR_IN,
  input wire logic         FB_RD_IN,
  input wire logic [7:0]   FB_RDATA_OUT,
  input wire logic [47:0]  COM_LEVEL_OUT,
  input wire logic [143:0] SEG_LEVEL_OUT,
  input wire logic [15:0]  PAD_IS_SEG_OUT,
  input wire logic         ALT_OUT,
  input wire logic         PUMP_ON_OUT,
  input wire logic         PUMP_BYPASS_OUT,
  input wire logic         QUARTER_BIAS_OUT,
  input wire logic [4:0]   CONTRAST_LEVEL_OUT
);
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (!RST_N_IN);
  logic wr_en;
  assign wr_en = REG_WR_IN & CLK_EN_IN;
  AST_PUMP:
  assert property (wr_en && REG_ADDR_IN == 8'h3a |=> PUMP_ON_OUT == !$past(REG_WDATA_IN[7]))
    else $error("pump state wrong");
  AST_BYPASS:
  assert property (wr_en && REG_ADDR_IN == 8'h3b |=> PUMP_BYPASS_OUT == $past(REG_WDATA_IN[3]))
    else $error("bypass wrong");
  AST_BIAS:
  assert property (wr_en && REG_ADDR_IN == 8'h39 |=> QUARTER_BIAS_OUT == $past(REG_WDATA_IN[5]))
    else $error("bias wrong");
  AST_PADS:
  assert property (wr_en && REG_ADDR_IN == 8'h39 |=> PAD_IS_SEG_OUT == ($past(REG_WDATA_IN[4])
    ? 16'hffff >> (4'hf - $past(REG_WDATA_IN[3:0])) : 16'h0)) else $error("pad map wrong");
  AST_HOLE:
  assert property (FB_RD_IN && CLK_EN_IN && FB_ADDR_IN inside {[13'h1030:13'h107f]}
    |=> FB_RDATA_OUT == 8'h0) else $error("hole read not zero");
  AST_ALT:
  assert property ($changed(ALT_OUT) |=> $stable(ALT_OUT) [*8]) else $error("alt too fast");
  AST_COM:
  assert property (ALT_OUT ? COM_LEVEL_OUT[2:0] inside {3'h5, 3'h1}
    : COM_LEVEL_OUT[2:0] inside {3'h0, 3'h4}) else $error("common level wrong");
  AST_SEG:
  assert property (ALT_OUT ? SEG_LEVEL_OUT[2:0] inside {3'h5, 3'h2}
    : SEG_LEVEL_OUT[2:0] inside {3'h0, 3'h3}) else $error("segment level wrong");
  AST_CTR:
  assert property ($changed(CONTRAST_LEVEL_OUT) |-> $changed(ALT_OUT))
    else $error("contrast mid frame");
  cover property (REG_RD_IN && REG_ADDR_IN == 8'h3a);
  cover property (PAD_IS_SEG_OUT == 16'hffff);
  cover property ($rose(ALT_OUT));
endmodule // lpd_ctrl_monitor
bind lpd_panel_ctrl lpd_ctrl_monitor mon (.*);

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  logic         clk, rst_n, wr, rd, fwr, frd, slow;
  logic [7:0]   a, wd, fwd;
  logic [12:0]  fa;
  wire  [7:0]   rdat, fdat;
  wire  [47:0]  com;
  wire  [143:0] seg;
  wire  [15:0]  pads;
  wire  [4:0]   ctr, drv;
  wire          alt, pon, byp, qb, dark;
  logic [7:0]   exp_q[$];
  int           err_total = 0, n_tests = 0, seed = 32'hb19b, i, v, k;
  lpd_panel_ctrl #(.ROW_64_CYC(4), .ROW_85_CYC(4)) uut (.MCLK_IN(clk), .RST_N_IN(rst_n),
    .CLK_EN_IN(1'b1), .REG_ADDR_IN(a), .REG_WDATA_IN(wd), .REG_WR_IN(wr), .REG_RD_IN(rd),
    .REG_RDATA_OUT(rdat), .FB_ADDR_IN(fa), .FB_WDATA_IN(fwd), .FB_WR_IN(fwr),
    .FB_RD_IN(frd), .FB_RDATA_OUT(fdat), .SLOW_OSC_IN(slow), .POWER_DOWN_IN(1'b0),
    .COM_LEVEL_OUT(com), .SEG_LEVEL_OUT(seg), .PAD_IS_SEG_OUT(pads), .ALT_OUT(alt),
    .PUMP_ON_OUT(pon), .PUMP_BYPASS_OUT(byp), .QUARTER_BIAS_OUT(qb),
    .CONTRAST_LEVEL_OUT(ctr), .DRIVE_LEVEL_OUT(drv));
  lpd_glass_model glass (.com_in(com), .seg_in(seg), .dark_out(dark));
  initial
  begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    slow = 0;
    forever #15259 slow = ~slow;
  end
  task close_out;
    if (err_total == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e)
    begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task rg(input logic w, input logic [7:0] ad, input logic [7:0] dv);
    @(posedge clk);
    a <= ad; wd <= dv; wr <= w; rd <= !w;
    @(posedge clk);
    wr <= 0; rd <= 0;
    #1;
  endtask
  task fb(input logic w, input logic [12:0] ad, input logic [7:0] dv);
    @(posedge clk);
    fa <= ad; fwd <= dv; fwr <= w; frd <= !w;
    @(posedge clk);
    fwr <= 0; frd <= 0;
    #1;
  endtask
  task wt(input logic sel);
    logic p;
    p = alt;
    k = 0;
    while ((sel ? alt === p : !(com[2:0] === 3'h5 || com[2:0] === 3'h0)) && k < 500)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k >= 500)
    begin
      err_total++;
      close_out;
    end
  endtask
  function logic [15:0] ectr(input logic d12, input logic f85, input int c);
    if (d12)
      return f85 ? (c < 7 ? 10 : 16 - c) : 16 - c;
    return f85 ? (c < 9 ? 8 : 16 - c) : (c < 4 ? 12 : 16 - c);
  endfunction
  initial
  begin
    rst_n = 0; wr = 0; rd = 0; fwr = 0; frd = 0; a = 0; wd = 0; fa = 0; fwd = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    rg(0, 8'h39, 0); chk(rdat, 8'h1f);
    rg(0, 8'h3a, 0); chk(rdat, 8'h80);
    rg(0, 8'h3b, 0); chk(rdat, 8'hf0);
    rg(1, 8'h3d, 8'hff); rg(0, 8'h3d, 0); chk(rdat, 0);
    for (i = 0; i < 32; i++)
    begin
      v = $random(seed);
      rg(1, 8'h39, {v[7:5], i[4:0]}); rg(0, 8'h39, 0); chk(rdat, {v[7:5], i[4:0]});
      chk(qb, v[5]);
      chk(pads, i[4] ? 16'hffff >> (15 - i[3:0]) : 16'h0);
      rg(1, 8'h3b, v[15:8]); chk(byp, v[11]);
      rg(1, 8'h3a, v[23:16]); chk(pon, !v[23]);
    end
    for (i = 0; i < 48; i++)
    begin
      v = $random(seed);
      fb(1, 13'h1000 + i, v[7:0]); fb(1, 13'h1080 + i, v[15:8]);
      exp_q.push_back(v[7:0]); exp_q.push_back(v[15:8]);
      fb(0, 13'h1000 + i, 0); chk(fdat, exp_q.pop_front());
      fb(0, 13'h1080 + i, 0); chk(fdat, exp_q.pop_front());
    end
    fb(0, 13'h1040, 0); chk(fdat, 0);
    fb(1, 13'h1000, 8'h80); fb(1, 13'h1001, 8'h00);
    rg(1, 8'h39, 8'h1f); rg(1, 8'h3b, 8'hf2);
    rg(1, 8'h3a, 8'h40); rg(1, 8'h3a, 8'h00);
    wt(0); chk(dark, 1); chk(seg[5:3], alt ? 3'h2 : 3'h3);
    rg(1, 8'h3a, 8'h20); wt(0); chk(dark, 0);
    rg(1, 8'h3a, 8'h60); wt(0); chk(dark, 0);
    rg(1, 8'h3a, 8'h10); wt(0); chk(seg[98:96], 3'h5);
    for (i = 0; i < 16; i++)
    begin
      v = $random(seed);
      rg(1, 8'h39, {i[0] ? 2'b10 : {2{i[2]}}, 6'h1f});
      rg(1, 8'h3b, {i[3:0], 3'b001, i[1]});
      rg(1, 8'h3a, {4'h0, v[3:0]});
      wt(1); wt(1); chk(ctr, ectr(i[0], i[1], v[3:0]));
      if (i[1:0] == 0) chk(drv, 16 - i[3:0]);
    end
    rg(1, 8'h39, 8'hdf); v = 0;
    repeat (200)
    begin
      @(posedge clk);
      #1;
      if (com[26:24] === 3'h5 || com[26:24] === 3'h0) v++;
    end
    chk(v[15:0], 0);
    close_out;
  end
endmodule // testbench
